// ===== design/serial_params.svh
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH

// register byte offsets
`define CTRL_OFF        8'h00
`define CMD_OFF         8'h0c
`define STATUS_OFF      8'h10
`define DIV_OFF         8'h14
`define RXWORD_X_OFF    8'h18
`define RXWORD_OFF      8'h1c
`define TXWORD_OFF      8'h34
`define IRQ_FLAG_OFF    8'h40
`define IRQ_MASK_OFF    8'h44

// control fields
`define CTRL_I2S_BIT    0
`define CTRL_HALF_BIT   1
`define CTRL_AUTOHIZ_BIT 2

// command fields
`define CMD_RX_ON       0
`define CMD_RX_OFF      1
`define CMD_TX_ON       2
`define CMD_TX_OFF      3
`define CMD_CTL_ON      4
`define CMD_CTL_OFF     5
`define CMD_BLK_ON      6
`define CMD_BLK_OFF     7
`define CMD_HIZ_ON      8
`define CMD_HIZ_OFF     9
`define CMD_CLR_TX      10
`define CMD_CLR_RX      11

// divider field
`define DIV_LSB         6
`define DIV_MSB         20
`define DIV_RESET       15'h0000

// interrupt flag positions
`define IRQ_TXDONE      0
`define IRQ_RXVALID     1
`define IRQ_RX_BUFFER_FULL_FLAG      2
`define IRQ_RXDROP      3

// buffer depth and status reset
`define BUF_DEPTH       2'h2
`define STATUS_RESET    13'h0040

`endif

// ===== design/serial_pkg.sv
`default_nettype none
package serial_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_t;

  // bit order matches the status word, bit 12 down to bit 0
  typedef struct packed {
    logic rx_full_right_flag;
    logic rx_next_is_right_flag;
    logic tx_wants_one_right_flag;
    logic tx_wants_two_right_flag;
    logic rx_buffer_full_flag;
    logic rx_word_valid_flag;
    logic tx_level_flag;
    logic tx_done_flag;
    logic tx_hiz_flag;
    logic rx_drop_flag;
    logic controller_role_flag;
    logic tx_enabled_flag;
    logic rx_enabled_flag;
  } status_t;

  typedef struct packed {
    logic i2s_mode;
    logic tx_half_threshold_select;
    logic auto_hiz_option;
  } ctrl_t;

endpackage
`default_nettype wire

// ===== design/rx_tracker.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_params.svh"

module rx_tracker
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // events
  input  wire logic       frame_done,
  input  wire logic       frame_right,
  input  wire logic       blocked,
  input  wire logic       pop,
  input  wire logic       clear,
  // state
  output logic [1:0]      count,
  output logic            head_right,
  output logic            all_right,
  output logic            stored,
  output logic            dropped
);

  typedef struct packed {
    logic [1:0] cnt;
    logic [1:0] ch;
    logic       stored;
    logic       dropped;
  } st_t;

  st_t s_q;
  st_t s_d;

  always_comb
  begin
    logic [1:0] c;
    logic [1:0] h;
    c = s_q.cnt;
    h = s_q.ch;
    s_d = s_q;
    s_d.stored = 1'b0;
    s_d.dropped = 1'b0;
    if (pop && c != 2'h0)
    begin
      h = {1'b0, h[1]};
      c = c - 2'h1;
    end
    if (frame_done)
    begin
      // a blocked frame never reaches the buffer
      if (blocked)
        s_d.dropped = 1'b1;
      else if (c != `BUF_DEPTH)
      begin
        h[c[0]] = frame_right;
        c = c + 2'h1;
        s_d.stored = 1'b1;
      end
      else
        s_d.dropped = 1'b1;
    end
    if (clear)
    begin
      c = 2'h0;
      h = 2'h0;
    end
    s_d.cnt = c;
    s_d.ch = h;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign count = s_q.cnt;
  assign head_right = s_q.ch[0] && s_q.cnt != 2'h0;
  assign all_right = s_q.cnt == `BUF_DEPTH && s_q.ch == 2'h3;
  assign stored = s_q.stored;
  assign dropped = s_q.dropped;

endmodule

`default_nettype wire

// ===== design/tx_tracker.sv
`timescale 1ns/10ps
`default_nettype none
`include "serial_params.svh"

module tx_tracker
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // events
  input  wire logic       push,
  input  wire logic       load,
  input  wire logic       frame_done,
  input  wire logic       clear,
  input  wire logic       i2s_mode,
  // state
  output logic [1:0]      count,
  output logic            expect_right,
  output logic            done
);

  typedef struct packed {
    logic [1:0] cnt;
    logic       right;
    logic       done;
  } st_t;

  st_t s_q;
  st_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (load && s_q.cnt != 2'h0)
      s_d.cnt = s_q.cnt - 2'h1;
    if (push && s_d.cnt != `BUF_DEPTH)
    begin
      s_d.cnt = s_d.cnt + 2'h1;
      s_d.right = i2s_mode && !s_q.right;
    end
    if (push)
      s_d.done = 1'b0;
    // set wins over the clear by a same-cycle write
    if (frame_done && s_q.cnt == 2'h0 && !load)
      s_d.done = 1'b1;
    if (clear)
    begin
      s_d.cnt = 2'h0;
      s_d.right = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign count = s_q.cnt;
  assign expect_right = s_q.right;
  assign done = s_q.done;

endmodule

`default_nettype wire

// ===== design/serial_status.sv
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "serial_params.svh"

// How it works
// - i2s: bit 12 when rx buffer full and both entries right
// - i2s: bit 10 when tx expects right next
// - i2s: bit 9 when tx expects two rights
// - bit 8 while rx buffer full
// - bit 7 while rx buffer nonempty
// - bit 6 resets one, empty tx sets it
// - bit 5 on idle finish, cleared by write
// - bit 4 while tristated, zero under auto
// - bit 3 blocks, completed frames dropped
// - bit 2 follows controller on/off commands
// - receiver off mid-frame discards the frame
module serial_status
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // receive datapath
  input  wire logic        rx_frame_done,
  input  wire logic        rx_frame_right,
  input  wire logic        rx_busy,
  output logic             rx_abort,
  output logic             rx_store,
  // transmit datapath
  input  wire logic        tx_load,
  input  wire logic        tx_frame_done,
  input  wire logic        tx_active,
  output logic             tx_oe,
  output logic             tx_pending,
  // configuration out
  output logic             controller_role,
  output logic             tx_enabled,
  output logic             rx_enabled,
  output logic [14:0]      baud_div,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    serial_pkg::ctrl_t   ctrl;
    serial_pkg::status_t stat;
    logic [14:0]         div;
    logic [3:0]          iflag;
    logic [3:0]          imask;
    logic                hiz;
    logic [31:0]         rdata;
    logic                rx_abort;
    logic                rx_store;
    logic                tx_oe;
    logic                tx_pending;
    logic                irq;
  } st_t;

  st_t s_q;
  st_t s_d;

  serial_pkg::bus_req_t req;

  logic [1:0] rx_count;
  logic       rx_head_right;
  logic       rx_all_right;
  logic       rx_stored;
  logic       rx_dropped;
  logic [1:0] tx_count;
  logic       tx_expect_right;
  logic       tx_done;
  logic       clr_rx;
  logic       clr_tx;
  logic       rx_pop;
  logic       tx_push;

  function automatic logic cmd_bit(input serial_pkg::bus_req_t r, input int unsigned b);
    cmd_bit = r.wr && r.addr == `CMD_OFF && r.wdata[b];
  endfunction

  function automatic logic hit_rd(input serial_pkg::bus_req_t r, input logic [7:0] a);
    hit_rd = r.rd && r.addr == a;
  endfunction

  assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};
  assign clr_rx = cmd_bit(req, `CMD_CLR_RX);
  assign clr_tx = cmd_bit(req, `CMD_CLR_TX);
  // reading either receive word register takes one word out
  assign rx_pop = hit_rd(req, `RXWORD_OFF) || hit_rd(req, `RXWORD_X_OFF);
  assign tx_push = wr && addr == `TXWORD_OFF;

  rx_tracker u_rx
  (
    .clock       (clock),
    .rst         (rst),
    .frame_done  (rx_frame_done && s_q.stat.rx_enabled_flag),
    .frame_right (rx_frame_right),
    .blocked     (s_q.stat.rx_drop_flag),
    .pop         (rx_pop),
    .clear       (clr_rx),
    .count       (rx_count),
    .head_right  (rx_head_right),
    .all_right   (rx_all_right),
    .stored      (rx_stored),
    .dropped     (rx_dropped)
  );

  tx_tracker u_tx
  (
    .clock        (clock),
    .rst          (rst),
    .push         (tx_push),
    .load         (tx_load),
    .frame_done   (tx_frame_done),
    .clear        (clr_tx),
    .i2s_mode     (s_q.ctrl.i2s_mode),
    .count        (tx_count),
    .expect_right (tx_expect_right),
    .done         (tx_done)
  );

  always_comb
  begin
    logic [3:0]  ev;
    logic [31:0] rv;
    logic        i2s;
    ev = 4'h0;
    rv = 32'h0000_0000;
    i2s = s_q.ctrl.i2s_mode;
    s_d = s_q;
    s_d.rx_abort = 1'b0;

    // control register, own layout
    if (wr && addr == `CTRL_OFF)
    begin
      s_d.ctrl.i2s_mode = wdata[`CTRL_I2S_BIT];
      s_d.ctrl.tx_half_threshold_select = wdata[`CTRL_HALF_BIT];
      s_d.ctrl.auto_hiz_option = wdata[`CTRL_AUTOHIZ_BIT];
    end

    // commands; an off after an on in the same word wins
    if (cmd_bit(req, `CMD_RX_ON))
      s_d.stat.rx_enabled_flag = 1'b1;
    if (cmd_bit(req, `CMD_RX_OFF))
    begin
      s_d.stat.rx_enabled_flag = 1'b0;
      s_d.rx_abort = rx_busy;
    end
    if (cmd_bit(req, `CMD_TX_ON))
      s_d.stat.tx_enabled_flag = 1'b1;
    if (cmd_bit(req, `CMD_TX_OFF))
      s_d.stat.tx_enabled_flag = 1'b0;
    // ordering against the transmitter enable is left to software
    if (cmd_bit(req, `CMD_CTL_ON))
      s_d.stat.controller_role_flag = 1'b1;
    if (cmd_bit(req, `CMD_CTL_OFF))
      s_d.stat.controller_role_flag = 1'b0;
    if (cmd_bit(req, `CMD_BLK_ON))
      s_d.stat.rx_drop_flag = 1'b1;
    if (cmd_bit(req, `CMD_BLK_OFF))
      s_d.stat.rx_drop_flag = 1'b0;
    if (cmd_bit(req, `CMD_HIZ_ON))
      s_d.hiz = 1'b1;
    if (cmd_bit(req, `CMD_HIZ_OFF))
      s_d.hiz = 1'b0;

    // divider
    if (wr && addr == `DIV_OFF)
      s_d.div = wdata[`DIV_MSB:`DIV_LSB];

    // status flags, taken from current registered tracker state one cycle late
    s_d.stat.rx_full_right_flag = i2s && rx_all_right;
    s_d.stat.rx_next_is_right_flag = i2s && rx_head_right;
    s_d.stat.tx_wants_one_right_flag = i2s && tx_expect_right;
    // two rights only fit while both slots are free
    s_d.stat.tx_wants_two_right_flag = i2s && tx_expect_right
                                       && tx_count == 2'h0;
    s_d.stat.rx_buffer_full_flag = rx_count == `BUF_DEPTH;
    s_d.stat.rx_word_valid_flag = rx_count != 2'h0;
    s_d.stat.tx_level_flag = s_q.ctrl.tx_half_threshold_select
                             ? tx_count != `BUF_DEPTH
                             : tx_count == 2'h0;
    s_d.stat.tx_done_flag = tx_done;
    s_d.stat.tx_hiz_flag = s_q.hiz && !s_q.ctrl.auto_hiz_option;

    // pin drive: auto mode tristates whenever nothing is being sent
    s_d.tx_oe = s_q.ctrl.auto_hiz_option ? tx_active : !s_q.hiz;
    s_d.tx_pending = tx_count != 2'h0;
    s_d.rx_store = rx_stored;

    // interrupts: set wins over write-one-to-clear
    ev[`IRQ_TXDONE] = tx_done && !s_q.stat.tx_done_flag;
    ev[`IRQ_RXVALID] = rx_stored;
    ev[`IRQ_RX_BUFFER_FULL_FLAG] = rx_count == `BUF_DEPTH && !s_q.stat.rx_buffer_full_flag;
    ev[`IRQ_RXDROP] = rx_dropped;
    if (wr && addr == `IRQ_FLAG_OFF)
      s_d.iflag = s_q.iflag & ~wdata[3:0];
    s_d.iflag = s_d.iflag | ev;
    if (wr && addr == `IRQ_MASK_OFF)
      s_d.imask = wdata[3:0];
    s_d.irq = |(s_d.iflag & s_d.imask);

    // read data stands only in the cycle after the strobe
    if (rd)
    begin
      unique case (addr)
        `CTRL_OFF:     rv = {29'h0, s_q.ctrl.auto_hiz_option,
                             s_q.ctrl.tx_half_threshold_select, s_q.ctrl.i2s_mode};
        `STATUS_OFF:   rv = {19'h0, s_q.stat};
        `DIV_OFF:      rv = {11'h0, s_q.div, 6'h00};
        `IRQ_FLAG_OFF: rv = {28'h0, s_q.iflag};
        `IRQ_MASK_OFF: rv = {28'h0, s_q.imask};
        default:       rv = 32'h0000_0000;
      endcase
    end
    s_d.rdata = rv;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.stat <= serial_pkg::status_t'(`STATUS_RESET);
      s_q.div <= `DIV_RESET;
      s_q.tx_oe <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign rdata = s_q.rdata;
  assign rx_abort = s_q.rx_abort;
  assign rx_store = s_q.rx_store;
  assign tx_oe = s_q.tx_oe;
  assign tx_pending = s_q.tx_pending;
  assign controller_role = s_q.stat.controller_role_flag;
  assign tx_enabled = s_q.stat.tx_enabled_flag;
  assign rx_enabled = s_q.stat.rx_enabled_flag;
  assign baud_div = s_q.div;
  assign irq = s_q.irq;

endmodule

`default_nettype wire

// ===== verification/serial_status_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module serial_status_assertions
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [31:0] rdata,
  // datapath
  input  wire logic        rx_frame_done,
  input  wire logic        rx_busy,
  input  wire logic        rx_abort,
  input  wire logic        rx_store,
  input  wire logic        tx_load,
  input  wire logic        tx_pending,
  // configuration
  input  wire logic        controller_role,
  input  wire logic        tx_enabled,
  input  wire logic        rx_enabled,
  input  wire logic [14:0] baud_div
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  property p_rd_idle;
    !rd |=> rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

  property p_status_rsvd;
    rd && addr == 8'h10 |=> rdata[31:13] == 19'h0;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status high bits set");

  property p_div_read;
    rd && addr == 8'h14 |=> rdata == {11'h0, baud_div, 6'h0};
  endproperty
  a_div_read: assert property (p_div_read) else $error("divider read wrong");

  property p_div_write;
    wr && addr == 8'h14 |=> baud_div == $past(wdata[20:6]);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider not taken");

  property p_status_en;
    rd && addr == 8'h10 |=> rdata[2:0] == {controller_role, tx_enabled, rx_enabled};
  endproperty
  a_status_en: assert property (p_status_en) else $error("enable bits differ");

  property p_store_cause;
    rx_store |-> $past(rx_frame_done, 2) && $past(rx_enabled, 2);
  endproperty
  a_store_cause: assert property (p_store_cause) else $error("store without frame");

  property p_ignored;
    rx_frame_done && !rx_enabled |-> ##2 !rx_store;
  endproperty
  a_ignored: assert property (p_ignored) else $error("frame stored while off");

  property p_abort;
    $fell(rx_enabled) && $past(rx_busy) |-> ##[0:1] rx_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("partial frame kept");

  property p_tx_pending;
    wr && addr == 8'h34 && !tx_load ##1 !tx_load |-> ##1 tx_pending;
  endproperty
  a_tx_pending: assert property (p_tx_pending) else $error("push not seen");
endmodule

bind serial_status serial_status_assertions chk
(
  .clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
  .rx_frame_done, .rx_busy, .rx_abort, .rx_store, .tx_load, .tx_pending,
  .controller_role, .tx_enabled, .rx_enabled, .baud_div
);
`default_nettype wire

// ===== verification/serial_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module serial_link_model
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // bench requests
  input  wire logic rx_go,
  input  wire logic rx_side,
  input  wire logic tx_go,
  // lines toward the block
  output logic      rx_frame_done,
  output logic      rx_frame_right,
  output logic      rx_busy,
  output logic      tx_load,
  output logic      tx_frame_done,
  output logic      tx_active
);
  logic [2:0] rx_cnt_q;
  logic [2:0] tx_cnt_q;
  logic       side_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      {rx_frame_done, rx_frame_right, rx_busy, side_q} <= 4'h0;
      {tx_load, tx_frame_done, tx_active} <= 3'h0;
      rx_cnt_q <= 3'h0;
      tx_cnt_q <= 3'h0;
    end
    else
    begin
      rx_frame_done <= 1'b0;
      tx_load <= 1'b0;
      tx_frame_done <= 1'b0;
      // channel line means nothing between frames, so keep it moving
      rx_frame_right <= ~rx_frame_right;
      if (rx_go)
      begin
        rx_cnt_q <= 3'h6;
        rx_busy <= 1'b1;
        side_q <= rx_side;
      end
      else if (rx_cnt_q != 3'h0)
      begin
        rx_cnt_q <= rx_cnt_q - 3'h1;
        if (rx_cnt_q == 3'h1)
        begin
          rx_busy <= 1'b0;
          rx_frame_done <= 1'b1;
          rx_frame_right <= side_q;
        end
      end
      if (tx_go)
      begin
        tx_load <= 1'b1;
        tx_active <= 1'b1;
        tx_cnt_q <= 3'h4;
      end
      else if (tx_cnt_q != 3'h0)
      begin
        tx_cnt_q <= tx_cnt_q - 3'h1;
        if (tx_cnt_q == 3'h1)
        begin
          tx_active <= 1'b0;
          tx_frame_done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_serial_status.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serial_status;
  logic        clock, rst, wr, rd, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        rx_frame_done, rx_frame_right, rx_busy, rx_abort, rx_store;
  logic        tx_load, tx_frame_done, tx_active, tx_oe, tx_pending;
  logic        controller_role, tx_enabled, rx_enabled;
  logic [14:0] baud_div;
  logic        rx_go, rx_side, tx_go;
  int          miscompares, checked, cycles;

  serial_status dut
  (
    .clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .rx_frame_done, .rx_frame_right, .rx_busy, .rx_abort, .rx_store,
    .tx_load, .tx_frame_done, .tx_active, .tx_oe, .tx_pending,
    .controller_role, .tx_enabled, .rx_enabled, .baud_div, .irq
  );

  serial_link_model peer
  (
    .clock, .rst, .rx_go, .rx_side, .tx_go,
    .rx_frame_done, .rx_frame_right, .rx_busy, .tx_load, .tx_frame_done, .tx_active
  );

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic end_sim;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // a run of this length finishes well under the ceiling
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic rx_start(input logic side);
    @(posedge clock);
    rx_go <= 1'b1;
    rx_side <= side;
    @(posedge clock);
    rx_go <= 1'b0;
  endtask

  task automatic rx_frame(input logic side);
    rx_start(side);
    repeat (10) @(posedge clock);
  endtask

  task automatic tx_frame;
    @(posedge clock);
    tx_go <= 1'b1;
    @(posedge clock);
    tx_go <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  initial
  begin
    {rst, wr, rd, rx_go, rx_side, tx_go} = 6'h20;
    addr = 8'h0;
    wdata = 32'h0;
    {miscompares, checked, cycles} = '0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd_chk(8'h10, 32'h40);
    chk({31'h0, tx_oe}, 32'h1);
    rd_chk(8'h14, 32'h0);
    wr_reg(8'h14, 32'hffffffff);
    rd_chk(8'h14, 32'h001fffc0);
    rd_chk(8'h80, 32'h0);
    wr_reg(8'h0c, 32'h15);
    rd_chk(8'h10, 32'h47);
    wr_reg(8'h0c, 32'h140);
    rd_chk(8'h10, 32'h5f);
    chk({31'h0, tx_oe}, 32'h0);
    rx_frame(1'b1);
    rd_chk(8'h10, 32'h5f);
    wr_reg(8'h0c, 32'h2a0);
    rd_chk(8'h10, 32'h43);
    chk({31'h0, tx_oe}, 32'h1);
    wr_reg(8'h44, 32'h2);
    wr_reg(8'h00, 32'h1);
    rx_frame(1'b1);
    rx_frame(1'b1);
    rd_chk(8'h10, 32'h19c3);
    chk({31'h0, irq}, 32'h1);
    rd_chk(8'h1c, 32'h0);
    rd_chk(8'h10, 32'h08c3);
    rx_frame(1'b0);
    rd_chk(8'h10, 32'h9c3);
    rd_chk(8'h18, 32'h0);
    rd_chk(8'h10, 32'hc3);
    rd_chk(8'h1c, 32'h0);
    rd_chk(8'h10, 32'h43);
    wr_reg(8'h40, 32'hf);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd_chk(8'h44, 32'h2);
    wr_reg(8'h34, 32'h0);
    rd_chk(8'h10, 32'h403);
    tx_frame();
    rd_chk(8'h10, 32'h663);
    wr_reg(8'h00, 32'h5);
    wr_reg(8'h0c, 32'h100);
    rd_chk(8'h10, 32'h663);
    chk({31'h0, tx_oe}, 32'h0);
    wr_reg(8'h34, 32'h0);
    rd_chk(8'h10, 32'h3);
    wr_reg(8'h00, 32'h7);
    rd_chk(8'h10, 32'h43);
    rx_start(1'b1);
    wr_reg(8'h0c, 32'h2);
    repeat (10) @(posedge clock);
    rd_chk(8'h10, 32'h42);
    wr_reg(8'h00, 32'h1);
    wr_reg(8'h34, 32'h0);
    rd_chk(8'h10, 32'h412);
    wr_reg(8'h0c, 32'h400);
    rd_chk(8'h10, 32'h52);
    chk({31'h0, tx_oe}, 32'h0);
    wr_reg(8'h0c, 32'h1);
    rx_frame(1'b0);
    wr_reg(8'h0c, 32'h800);
    rd_chk(8'h10, 32'h53);
    end_sim();
  end
endmodule
`default_nettype wire
